// *** pmjf_framer.sv ***
// Peak monitor with embedded reporting and transmit sample framer
//
// Functional notes
// - Peak detector works on magnitude only, result is 13 bits.
// - Observation period is 24 bits, counted in clk_sys cycles.
// - Peak detection runs only while monitor control bit 1 is set.
// - Enable loads period into timer; timer decrements every cycle.
// - Each cycle keep larger of input magnitude and hidden store.
// - Each measurement seeds the store with current sample magnitude.
// - At timer count 1 copy peak into holding register for link.
// - After transfer reload timer and reseed store from next sample.
// - Embedding needs control bits 1:0 and selector bit 1 set.
// - Control bits fill from most significant position downward.
// - Peak goes out as 25-bit frame, five subframes with start bits.
// - Lanes 1/2/4, converters 1/2/4/8, octets per frame 1/2/4/8/16.
// - Word size 8 or 16, resolution 7..16, control bits 0..3.
// - Frames per multiframe limited to multiples of four to 32.
// - Samples per frame and density derived; control words fixed zero.
// - Default two converters on four lanes, A on 0/1, B 2/3.
// - Sample bits 13..6 first octet; 5..0 plus two tails second.
// - Tails are zeros or pseudorandom, or replaced by control bits.
// - Optional self-synchronising scrambler 1 + x^14 + x^15.
// - Tail count is word size minus resolution minus control bits.
// - Samples packed converter 0 first, one converter at a time.
module pmjf_framer
    import pmjf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [SAMP_W-1:0] samp_a,
    input wire logic [SAMP_W-1:0] samp_b,
    input wire logic ovr_a,
    input wire logic ovr_b,
    output logic sample_take,
    output logic [9:0] lane0_output,
    output logic [9:0] lane1_output,
    output logic [9:0] lane2_output,
    output logic [9:0] lane3_output
);
    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic mon_en;
        logic [PERIOD_W-1:0] period;
        logic [1:0] emb_ctrl;
        logic emb_sel;
        logic [7:0] opt0;
        logic [7:0] opt1;
        logic [7:0] opt2;
        logic [LC_W-1:0] lcfg;
        logic [PERIOD_W-1:0] timer;
        logic [PEAK_W-1:0] store;
        logic seed;
        logic [PEAK_W-1:0] hold;
        logic [FRAME_LEN-1:0] ser;
        logic [4:0] ser_cnt;
        logic pend;
        logic [1:0] ph;
        logic take;
        logic [29:0] cap;
        logic [14:0] prn;
        logic [3:0][14:0] scr;
        logic [3:0] rd;
        logic [3:0][9:0] sym;
    } pmjf_state_t;

    pmjf_state_t state_reg;
    pmjf_state_t state_next;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [12:0] mag13(input logic [13:0] x);
        logic [13:0] a;
        a = x[13] ? 14'(-x) : x;
        // Full-scale negative has no positive twin; clip it
        return a[13] ? MAG_MAX : a[12:0];
    endfunction

    function automatic logic [22:0] scr8(input logic [7:0] d,
                                         input logic [14:0] st);
        logic [14:0] s;
        logic [7:0] o;
        logic b;
        s = st;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            b = d[i] ^ s[13] ^ s[14];
            o[i] = b;
            s = {s[13:0], b};
        end
        return {s, o};
    endfunction

    function automatic logic [10:0] enc8b10b(input logic [7:0] d,
                                             input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic rd6;
        logic bal6;
        logic bal4;
        logic alt;
        c6 = ENC6_TBL[d[4:0]];
        bal6 = ($countones(c6) == 3);
        if (rd && (!bal6 || d[4:0] == 5'h07)) begin
            c6 = ~c6;
        end
        rd6 = bal6 ? rd : ~rd;
        // Alternate x.7 avoids a run of five equal bits
        alt = (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
                        d[4:0] == 5'h14)) ||
              (rd6 && (d[4:0] == 5'h0b || d[4:0] == 5'h0d ||
                       d[4:0] == 5'h0e));
        c4 = (d[7:5] == 3'h7 && alt) ? ENC4_ALT7 : ENC4_TBL[d[7:5]];
        bal4 = ($countones(c4) == 2);
        if (rd6 && (!bal4 || d[7:5] == 3'h3)) begin
            c4 = ~c4;
        end
        return {bal4 ? rd6 : ~rd6, c6, c4};
    endfunction

    function automatic int slog(input logic [LC_W-1:0] c);
        return 3 + int'(c[LC_F_LSB +: 3]) + int'(c[LC_L_LSB +: 2])
            - int'(c[LC_M_LSB +: 2]) - (c[LC_NP_BIT] ? 4 : 3);
    endfunction

    function automatic logic cfg_legal(input logic [LC_W-1:0] c);
        int nb;
        int np;
        nb = int'(c[LC_N_LSB +: 4]) + 1;
        np = c[LC_NP_BIT] ? 16 : 8;
        return (c[LC_L_LSB +: 2] != 2'h3) && (c[LC_F_LSB +: 3] <= 3'h4)
            && (nb >= 7) && (nb + int'(c[LC_CS_LSB +: 2]) <= np)
            && (slog(c) >= 0);
    endfunction

    // -------------------------------------------------------------
    // Register decode
    // -------------------------------------------------------------
    logic [10:0] idx;
    logic hit;
    logic [31:0] rdata;
    logic wr_commit;
    logic [6:0] s_val;
    logic hd_val;

    assign idx = paddr[ADDR_W-1:2];
    assign wr_commit = psel & penable & state_reg.pready & pwrite &
                       ~state_reg.pslverr;
    assign s_val = 7'(1 << slog(state_reg.lcfg));
    assign hd_val = (state_reg.lcfg[LC_F_LSB +: 3] == 3'h0) &
                    state_reg.lcfg[LC_NP_BIT];

    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (idx)
            IDX_MON_CTRL: rdata[MON_EN_BIT] = state_reg.mon_en;
            IDX_MON_PERIOD: rdata[PERIOD_W-1:0] = state_reg.period;
            IDX_MON_HOLD: rdata[PEAK_W-1:0] = state_reg.hold;
            IDX_EMB_CTRL: rdata[1:0] = state_reg.emb_ctrl;
            IDX_EMB_SEL: rdata[EMB_SEL_BIT] = state_reg.emb_sel;
            IDX_LINK_OPT0: rdata[7:0] = state_reg.opt0;
            IDX_LINK_OPT1: rdata[7:0] = state_reg.opt1;
            IDX_LINK_OPT2: rdata[7:0] = state_reg.opt2;
            IDX_LINK_CFG: begin
                rdata[LC_W-1:0] = state_reg.lcfg;
                rdata[LC_S_LSB +: 7] = s_val;
                rdata[LC_HD_BIT] = hd_val;
            end
            default: hit = 1'b0;
        endcase
    end

    // -------------------------------------------------------------
    // Peak path and word building
    // -------------------------------------------------------------
    logic [PEAK_W-1:0] mag;
    logic [PEAK_W-1:0] cand;
    logic [PERIOD_W-1:0] per_eff;
    logic emb_en;
    logic mon_bit;
    logic [29:0] src;
    logic [15:0] word0;
    logic [15:0] word1;
    logic [3:0][7:0] octs;
    logic [3:0] lane_act;
    logic [3:0][1:0] osel;
    logic [1:0] ph_last;
    logic [19:0] payload;

    assign mag = mag13(samp_a);
    assign cand = (state_reg.seed || mag > state_reg.store) ?
                  mag : state_reg.store;
    // A zero period would never reach the transfer count
    assign per_eff = (state_reg.period == 24'h00_0000) ?
                     24'h00_0001 : state_reg.period;
    assign emb_en = (&state_reg.emb_ctrl) & state_reg.emb_sel;
    assign mon_bit = emb_en & (state_reg.ser_cnt != 5'h00) &
                     state_reg.ser[FRAME_LEN-1];
    assign src = (state_reg.ph == 2'h0) ?
                 {ovr_a, samp_a, ovr_b, samp_b} : state_reg.cap;
    assign payload = {7'h00, state_reg.hold};

    function automatic logic [15:0] mkword(input logic [13:0] x,
                                           input logic ovr,
                                           input logic [1:0] cs,
                                           input logic mb,
                                           input logic [1:0] tl);
        logic [1:0] ctl;
        unique case (cs)
            2'h0: ctl = tl;
            2'h1: ctl = {mb, tl[0]};
            default: ctl = {mb, ovr};
        endcase
        return {x, ctl};
    endfunction

    always_comb begin
        logic [1:0] tl;
        logic [1:0] cs;
        tl = state_reg.lcfg[LC_TAIL_BIT] ? state_reg.prn[1:0] : 2'h0;
        cs = state_reg.lcfg[LC_CS_LSB +: 2];
        // Remap swaps which converter feeds lanes 0/1 and 2/3
        if (state_reg.lcfg[LC_REMAP_BIT]) begin
            word0 = mkword(src[13:0], src[14], cs, mon_bit, tl);
            word1 = mkword(src[28:15], src[29], cs, mon_bit, tl);
        end else begin
            word0 = mkword(src[28:15], src[29], cs, mon_bit, tl);
            word1 = mkword(src[13:0], src[14], cs, mon_bit, tl);
        end
        octs = {word1[7:0], word1[15:8], word0[7:0], word0[15:8]};
    end

    always_comb begin
        osel = {2'h3, 2'h2, 2'h1, 2'h0};
        unique case (state_reg.lcfg[LC_L_LSB +: 2])
            2'h2: begin
                lane_act = 4'hf;
                ph_last = 2'h0;
            end
            2'h1: begin
                lane_act = 4'h5;
                ph_last = 2'h1;
                osel[0] = {1'b0, state_reg.ph[0]};
                osel[2] = {1'b1, state_reg.ph[0]};
            end
            default: begin
                lane_act = 4'h1;
                ph_last = 2'h3;
                osel[0] = state_reg.ph;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        logic [22:0] sc;
        logic [10:0] en;
        sc = 23'h00_0000;
        en = 11'h000;
        state_next = state_reg;
        // Bus: one wait state, answer on the second access cycle
        state_next.pready = psel & penable & ~state_reg.pready;
        state_next.pslverr = 1'b0;
        if (psel & penable & ~state_reg.pready) begin
            state_next.prdata = rdata;
            state_next.pslverr = ~hit | (pwrite & (idx == IDX_LINK_CFG) &
                ~cfg_legal(pwdata[LC_W-1:0]));
        end
        if (wr_commit) begin
            case (idx)
                IDX_MON_CTRL: state_next.mon_en = pwdata[MON_EN_BIT];
                IDX_MON_PERIOD:
                    state_next.period = pwdata[PERIOD_W-1:0];
                IDX_EMB_CTRL: state_next.emb_ctrl = pwdata[1:0];
                IDX_EMB_SEL: state_next.emb_sel = pwdata[EMB_SEL_BIT];
                IDX_LINK_OPT0: state_next.opt0 = pwdata[7:0];
                IDX_LINK_OPT1: state_next.opt1 = pwdata[7:0];
                IDX_LINK_OPT2: state_next.opt2 = pwdata[7:0];
                IDX_LINK_CFG: state_next.lcfg = pwdata[LC_W-1:0];
                default: ;
            endcase
        end
        // Monitor frame goes out one bit per sample
        if (state_reg.take && state_reg.ser_cnt != 5'h00) begin
            state_next.ser = {state_reg.ser[FRAME_LEN-2:0], 1'b0};
            state_next.ser_cnt = state_reg.ser_cnt - 5'h01;
        end
        if (state_reg.ser_cnt == 5'h00 && state_reg.pend) begin
            state_next.ser = {1'b1, payload[19:16], 1'b1, payload[15:12],
                              1'b1, payload[11:8], 1'b1, payload[7:4],
                              1'b1, payload[3:0]};
            state_next.ser_cnt = FRAME_CNT;
            state_next.pend = 1'b0;
        end
        // Peak detector; expiry sets pend after the load clears it
        if (!state_reg.mon_en) begin
            state_next.timer = 24'h00_0000;
            state_next.seed = 1'b1;
        end else if (state_reg.timer == 24'h00_0000) begin
            state_next.timer = per_eff;
            state_next.seed = 1'b1;
        end else begin
            state_next.store = cand;
            state_next.seed = 1'b0;
            if (state_reg.timer == 24'h00_0001) begin
                state_next.hold = cand;
                state_next.timer = per_eff;
                state_next.seed = 1'b1;
                state_next.pend = 1'b1;
            end else begin
                state_next.timer = state_reg.timer - 24'h00_0001;
            end
        end
        // Frame sequencer: fewer lanes take more cycles per frame
        state_next.ph = (state_reg.ph == ph_last) ?
                        2'h0 : state_reg.ph + 2'h1;
        state_next.take = (state_next.ph == 2'h0);
        if (state_reg.ph == 2'h0) begin
            state_next.cap = src;
        end
        state_next.prn = {state_reg.prn[13:0],
                          state_reg.prn[14] ^ state_reg.prn[13]};
        for (int k = 0; k < 4; k++) begin
            if (lane_act[k]) begin
                if (state_reg.lcfg[LC_SCR_BIT]) begin
                    sc = scr8(octs[osel[k]], state_reg.scr[k]);
                end else begin
                    sc = {state_reg.scr[k], octs[osel[k]]};
                end
                en = enc8b10b(sc[7:0], state_reg.rd[k]);
                state_next.scr[k] = sc[22:8];
                state_next.rd[k] = en[10];
                state_next.sym[k] = en[9:0];
            end else begin
                state_next.sym[k] = 10'h000;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= '0;
            state_reg.lcfg <= LC_RESET;
            state_reg.seed <= 1'b1;
            state_reg.take <= 1'b1;
            state_reg.prn <= PRN_SEED;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign sample_take = state_reg.take;
    assign lane0_output = state_reg.sym[0];
    assign lane1_output = state_reg.sym[1];
    assign lane2_output = state_reg.sym[2];
    assign lane3_output = state_reg.sym[3];

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    chk_hold_on_expiry: assert property (
        (state_reg.mon_en && state_reg.timer == 24'h00_0001)
        |=> state_reg.hold == $past(cand))
        else $error("Holding register missed the expiry value");
    chk_hold_stable: assert property (
        !(state_reg.mon_en && state_reg.timer == 24'h00_0001)
        |=> $stable(state_reg.hold))
        else $error("Holding register changed between expiries");
    chk_timer_reload: assert property (
        (state_reg.mon_en && state_reg.timer == 24'h00_0001 &&
         !(wr_commit && idx == IDX_MON_CTRL))
        |=> (state_reg.timer == $past(per_eff) && state_reg.seed)
        ##1 state_reg.store == $past(mag))
        else $error("Timer not reloaded or store not reseeded");
    chk_timer_dec: assert property (
        (state_reg.mon_en && state_reg.timer > 24'h00_0001)
        |=> state_reg.timer == $past(state_reg.timer) - 24'h00_0001)
        else $error("Period timer did not decrement by one");
    chk_store_max: assert property (
        (state_reg.mon_en && state_reg.timer != 24'h00_0000 &&
         !state_reg.seed)
        |=> state_reg.store >= $past(state_reg.store) &&
            state_reg.store >= $past(mag))
        else $error("Running peak dropped below a seen magnitude");
    chk_seed_mag: assert property (
        (state_reg.mon_en && state_reg.timer == 24'h00_0000)
        ##1 state_reg.mon_en |=> state_reg.store == $past(mag))
        else $error("Measurement not seeded from current sample");
    chk_peak_off: assert property (
        !state_reg.mon_en |=> state_reg.timer == 24'h00_0000 &&
        $stable(state_reg.hold))
        else $error("Peak detector active while disabled");
    chk_frame_starts: assert property (
        state_reg.ser_cnt == FRAME_CNT |-> state_reg.ser[24] &&
        state_reg.ser[19] && state_reg.ser[14] && state_reg.ser[9] &&
        state_reg.ser[4])
        else $error("Monitor subframe start bit missing");
endmodule

// *** pmjf_pkg.sv ***
// Shared constants for the peak monitor and link sample framer
package pmjf_pkg;
    // -------------------------------------------------------------
    // Register map: byte address is four times the index
    // -------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [10:0] IDX_MON_CTRL = 11'h270;
    localparam logic [10:0] IDX_MON_PERIOD = 11'h271;
    localparam logic [10:0] IDX_MON_HOLD = 11'h272;
    localparam logic [10:0] IDX_EMB_CTRL = 11'h279;
    localparam logic [10:0] IDX_EMB_SEL = 11'h27a;
    localparam logic [10:0] IDX_LINK_OPT0 = 11'h559;
    localparam logic [10:0] IDX_LINK_OPT1 = 11'h55a;
    localparam logic [10:0] IDX_LINK_OPT2 = 11'h58f;
    localparam logic [10:0] IDX_LINK_CFG = 11'h5f0;
    // -------------------------------------------------------------
    // Field positions and widths
    // -------------------------------------------------------------
    localparam int MON_EN_BIT = 1;
    localparam int EMB_SEL_BIT = 1;
    localparam int PERIOD_W = 24;
    localparam int PEAK_W = 13;
    localparam int SAMP_W = 14;
    localparam int FRAME_LEN = 25;
    localparam logic [4:0] FRAME_CNT = 5'h19;
    localparam logic [12:0] MAG_MAX = 13'h1fff;
    localparam logic [14:0] PRN_SEED = 15'h7fff;
    // Link config word: lanes code (0:1, 1:2, 2:4), log2 M, log2 F,
    // word size (1:16), N-1, CS, K/4-1, scramble, tail prn, remap
    localparam int LC_W = 20;
    localparam int LC_L_LSB = 0;
    localparam int LC_M_LSB = 2;
    localparam int LC_F_LSB = 4;
    localparam int LC_NP_BIT = 7;
    localparam int LC_N_LSB = 8;
    localparam int LC_CS_LSB = 12;
    localparam int LC_K_LSB = 14;
    localparam int LC_SCR_BIT = 17;
    localparam int LC_TAIL_BIT = 18;
    localparam int LC_REMAP_BIT = 19;
    localparam int LC_S_LSB = 24;
    localparam int LC_HD_BIT = 31;
    // Four lanes, two converters, F=1, N'=16, N=14, K=32, scrambled
    localparam logic [19:0] LC_RESET = 20'h3_cd86;
    // -------------------------------------------------------------
    // 8b/10b code tables, running disparity negative forms
    // -------------------------------------------------------------
    localparam logic [5:0] ENC6_TBL [0:31] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] ENC4_TBL [0:7] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    localparam logic [3:0] ENC4_ALT7 = 4'h7;
endpackage

// *** pmjf_link_rx.sv ***
// Link receiver model: lane 0 disparity and lane 1 monitor frame rebuild
module pmjf_link_rx (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [9:0] lane0_output,
    input wire logic [9:0] lane1_output,
    output int rd_errs,
    output logic [24:0] mon_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_pos;
    logic [23:0] shf;
    logic [4:0] cnt;
    logic mbit;
    int ones;
    // Zero symbols are idle lanes, not code groups
    always @(posedge clk_sys) begin
        ones = $countones(lane0_output);
        // Only valid unscrambled: low octet 0x02 carries the monitor bit
        mbit = (lane1_output[9:4] == 6'h2d) ||
               (lane1_output[9:4] == 6'h12);
        if (sys_rst) begin
            rd_pos <= 1'h0;
            rd_errs <= 0;
            cnt <= 5'h00;
            shf <= 24'h00_0000;
            mon_frame <= 25'h000_0000;
        end else begin
            if (lane0_output != 10'h000) begin
                if ((ones == 6 && !rd_pos) || (ones == 4 && rd_pos))
                    rd_pos <= !rd_pos;
                else if (ones != 5)
                    rd_errs <= rd_errs + 1;
            end
            // Zeros between frames; a one starts 24 more bits
            if (cnt != 5'h00 || mbit) begin
                shf <= {shf[22:0], mbit};
                cnt <= (cnt == 5'h00) ? 5'h18 : cnt - 5'h01;
                if (cnt == 5'h01) begin
                    mon_frame <= {shf, mbit};
                end
            end
        end
    end
endmodule

// *** peak_monitor_jesd_sample_framer_bench.sv ***
// Self-checking bench for the peak monitor and sample framer
module peak_monitor_jesd_sample_framer_bench import pmjf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin \
    num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
    g, x); end end
    typedef struct {logic w; logic [10:0] idx; logic [31:0] d;
        logic [31:0] x; logic e;} pmjf_row_t;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sample_take, err;
    logic [SAMP_W-1:0] samp_a = '0;
    logic [SAMP_W-1:0] samp_b = '0;
    logic [SAMP_W-1:0] fixed_val = '0;
    logic pat_on = 1'h0;
    logic [1:0] k = '0;
    logic [9:0] lane0_output, lane1_output, lane2_output, lane3_output;
    logic [24:0] mon_frame;
    int num_errors = 0;
    int cmp_count = 0;
    int rd_errs, n;
    // Magnitudes 300, 7, 200, 50: every 4-sample window holds 300
    logic [SAMP_W-1:0] pat [0:3] = '{14'h3ed4, 14'h0007, 14'h00c8,
        14'h0032};
    pmjf_row_t rows [0:14] = '{
        '{1'h1, IDX_MON_PERIOD, 32'hffff_ffff, 32'h0, 1'h0},
        '{1'h0, IDX_MON_PERIOD, 32'h0, 32'h00ff_ffff, 1'h0},
        '{1'h1, IDX_MON_PERIOD, 32'h0000_0004, 32'h0, 1'h0},
        '{1'h0, IDX_MON_PERIOD, 32'h0, 32'h0000_0004, 1'h0},
        '{1'h1, IDX_EMB_CTRL, 32'h0000_0003, 32'h0, 1'h0},
        '{1'h0, IDX_EMB_CTRL, 32'h0, 32'h0000_0003, 1'h0},
        '{1'h1, IDX_EMB_SEL, 32'h0000_0002, 32'h0, 1'h0},
        '{1'h0, IDX_EMB_SEL, 32'h0, 32'h0000_0002, 1'h0},
        '{1'h1, IDX_LINK_OPT2, 32'h0000_003c, 32'h0, 1'h0},
        '{1'h0, IDX_LINK_OPT2, 32'h0, 32'h0000_003c, 1'h0},
        '{1'h1, IDX_MON_HOLD, 32'h0000_0123, 32'h0, 1'h0},
        '{1'h0, IDX_MON_HOLD, 32'h0, 32'h0, 1'h0},
        '{1'h1, 11'h100, 32'h0000_0001, 32'h0, 1'h1},
        '{1'h0, 11'h100, 32'h0, 32'h0, 1'h1},
        '{1'h1, IDX_LINK_CFG, 32'h0003_cd87, 32'h0, 1'h1}};
    // ----------------------------------------------------------
    // Clock, stimulus and instances
    // ----------------------------------------------------------
    initial begin
        forever #4 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys) begin
        k <= k + 2'h1;
        samp_a <= pat_on ? pat[k] : fixed_val;
    end
    pmjf_framer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .samp_a(samp_a), .samp_b(samp_b),
        .ovr_a(1'h0), .ovr_b(1'h0), .sample_take(sample_take),
        .lane0_output(lane0_output), .lane1_output(lane1_output),
        .lane2_output(lane2_output), .lane3_output(lane3_output));
    pmjf_link_rx i_rx (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .lane0_output(lane0_output), .lane1_output(lane1_output),
        .rd_errs(rd_errs), .mon_frame(mon_frame));
    // ----------------------------------------------------------
    // Bus cycle and verdict
    // ----------------------------------------------------------
    task automatic apb(input logic w, input logic [10:0] idx,
            input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        complete_run();
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'h0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].idx, rows[i].d);
            `CHK(err, rows[i].e)
            if (!rows[i].w) `CHK(rd, rows[i].x)
        end
        apb(1'h0, IDX_LINK_CFG, 32'h0);
        `CHK(rd[19:0], LC_RESET)
        fixed_val <= 14'h2000;
        apb(1'h1, IDX_MON_CTRL, 32'h0000_0002);
        repeat (30) @(posedge clk_sys);
        apb(1'h0, IDX_MON_HOLD, 32'h0);
        `CHK(rd, 32'h0000_1fff)
        fixed_val <= 14'h0005;
        repeat (30) @(posedge clk_sys);
        apb(1'h0, IDX_MON_HOLD, 32'h0);
        `CHK(rd, 32'h0000_0005)
        pat_on <= 1'h1;
        repeat (30) @(posedge clk_sys);
        apb(1'h0, IDX_MON_HOLD, 32'h0);
        `CHK(rd, 32'h0000_012c)
        apb(1'h1, IDX_MON_CTRL, 32'h0);
        pat_on <= 1'h0;
        fixed_val <= 14'h1000;
        repeat (30) @(posedge clk_sys);
        apb(1'h0, IDX_MON_HOLD, 32'h0);
        `CHK(rd, 32'h0000_012c)
        `CHK(rd_errs, 0)
        // Unscrambled, one control bit: monitor frame rides lane 1
        samp_b <= 14'h0080;
        apb(1'h1, IDX_LINK_CFG, 32'h0001_dd86);
        `CHK(err, 1'h0)
        apb(1'h1, IDX_LINK_OPT0, 32'h0000_0011);
        apb(1'h1, IDX_LINK_OPT1, 32'h0000_0022);
        repeat (30) @(posedge clk_sys);
        apb(1'h1, IDX_MON_CTRL, 32'h0000_0002);
        repeat (80) @(posedge clk_sys);
        // Hold 0x1000 as five start-marked nibbles
        `CHK(mon_frame, 25'h108_c210)
        `CHK(lane2_output[9:4] inside {6'h2d, 6'h12}, 1'h1)
        // One lane needs four octets per frame to stay legal
        apb(1'h1, IDX_LINK_CFG, 32'h0001_cda4);
        `CHK(err, 1'h0)
        repeat (8) @(posedge clk_sys);
        n = 0;
        repeat (8) begin
            @(posedge clk_sys);
            n += (sample_take === 1'h1);
            `CHK({lane1_output, lane2_output, lane3_output}, 30'h0)
        end
        `CHK(n, 2)
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        `CHK({lane0_output, pready, sample_take}, 12'h001)
        sys_rst <= 1'h0;
        apb(1'h0, IDX_MON_HOLD, 32'h0);
        `CHK(rd, 32'h0)
        complete_run();
    end
endmodule
